// file: hw/reset_seq_pkg.sv
package reset_seq_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned SYS_CLK_MHZ = 100;
   localparam int unsigned STARTUP_DELAY_CLKS = 1024;
   localparam int unsigned POWERON_EXTRA_CLKS = 1024;
   localparam int unsigned DELAY_WIDTH = 11;
   localparam logic [DELAY_WIDTH-1:0] DELAY_ZERO = 11'h000;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [11:0] PC_RESET = 12'h000;
   localparam logic [2:0] SP_RESET = 3'h0;
   localparam logic [7:0] DISPLAY_CTRL_INIT = 8'h07;
   localparam logic [7:0] TIMER0_CTRL_INIT = 8'h08;
   localparam logic [7:0] TIMER1_CTRL_INIT = 8'h08;
   localparam logic [7:0] INTC0_INIT = 8'h00;
   localparam logic [7:0] INTC1_INIT = 8'h00;
   localparam logic [7:0] PORT_DIR_INIT = 8'hFF;
   localparam logic [7:0] RTC_CTRL_INIT = 8'h07;

   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {ST_POWERON, ST_STARTUP, ST_RUN, ST_HALT} seq_state_type;
endpackage : reset_seq_pkg

// file: hw/startup_delay_timer.sv
`timescale 1ns/1ps
// Down counter that holds execution while the oscillator settles
module startup_delay_timer
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Control
   input wire logic start,
   input wire logic [reset_seq_pkg::DELAY_WIDTH-1:0] load_value,
   // Status
   output logic busy
);
   logic [reset_seq_pkg::DELAY_WIDTH-1:0] count_reg;
   logic [reset_seq_pkg::DELAY_WIDTH-1:0] count_next;

   // Reload on start, else count down to zero
   assign count_next = start ? load_value :
      (count_reg != reset_seq_pkg::DELAY_ZERO) ? count_reg - 11'h001 : count_reg;
   assign busy = (count_reg != reset_seq_pkg::DELAY_ZERO);

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         count_reg <= reset_seq_pkg::DELAY_ZERO;
      else
         count_reg <= count_next;
   end
endmodule : startup_delay_timer

// file: hw/mcu_reset_sequencer.sv
//  Summary of operation
// R1: Pin reset in run or halt, or watchdog time-out in run, gives chip reset.
// R2: Watchdog time-out in halt clears only PC and SP, sets time-out flag; code also reloads display driver control.
// R3: Time-out and power-down flags kept as status bits.
// R4: Pin reset: power-up 0/0, run unchanged, halt wake 0/1.
// R5: Watchdog: run time-out sets time-out flag; halt wake sets both.
// R6: Hold execution 1024 clocks after power-on and halt wake-up.
// R7: Power-on adds an extra delay; halt wake-up uses the normal delay only.
// R8: Chip reset: PC zero, interrupts off, timers off, ports input, SP top.
// R9: Chip reset clears watchdog counter; it restarts after reset ends.
// R10: Watchdog run time-out loads same control values as a pin reset.
// R11: Power-down flag cleared at power-up or clear instruction, set by halt.
// R12: Data registers untouched; control registers kept only on warm reset.
// R13: Display driver control reinitialised on every reset type.
`timescale 1ns/1ps
module mcu_reset_sequencer
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // External reset and watchdog events
   input wire logic external_reset_pin_n,
   input wire logic watchdog_timeout,
   // Instruction events from the core
   input wire logic halt_instruction,
   input wire logic watchdog_clear_instruction,
   // Status flags
   output logic watchdog_timeout_flag,
   output logic power_down_flag,
   // Reset strobes to the core and peripherals
   output logic core_hold,
   output logic chip_reset,
   output logic warm_reset,
   output logic watchdog_counter_clear,
   output logic halted,
   // Initial values for the core and peripherals
   output logic [11:0] pc_reset_value,
   output logic [2:0] sp_reset_value,
   output logic [7:0] timer0_ctrl_init,
   output logic [7:0] timer1_ctrl_init,
   output logic [7:0] intc0_init,
   output logic [7:0] intc1_init,
   output logic [7:0] port_dir_init,
   output logic [7:0] rtc_ctrl_init,
   output logic [7:0] display_driver_control_init,
   output logic display_driver_control_load,
   output logic ctrl_regs_load
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   // Registers and their next values
   reset_seq_pkg::seq_state_type state_reg;
   reset_seq_pkg::seq_state_type state_next;
   logic to_reg;
   logic to_next;
   logic pdf_reg;
   logic pdf_next;
   logic chip_reset_reg;
   logic warm_reset_reg;
   logic pin_seen_reg;
   // Decode and timer wires
   logic start_timer;
   logic [reset_seq_pkg::DELAY_WIDTH-1:0] load_value;
   logic timer_busy;
   logic [reset_seq_pkg::DELAY_WIDTH-1:0] poweron_load;
   logic [reset_seq_pkg::DELAY_WIDTH-1:0] wake_load;
   logic in_poweron;
   logic in_run;
   logic in_halt;
   logic pin_event;
   logic chip_cause;
   logic warm_cause;
   logic wake;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Shared state compare keeps every decode written the same way
   function automatic logic state_is(input reset_seq_pkg::seq_state_type cur,
      input reset_seq_pkg::seq_state_type want);
      return (cur == want);
   endfunction : state_is

   // ------------------------------------------------------------
   // Cause decode
   // ------------------------------------------------------------
   // Pin reset acts on its assertion edge so a held pin gives one reset
   assign in_poweron = state_is(state_reg, reset_seq_pkg::ST_POWERON);
   assign in_run = state_is(state_reg, reset_seq_pkg::ST_RUN);
   assign in_halt = state_is(state_reg, reset_seq_pkg::ST_HALT);
   assign pin_event = !external_reset_pin_n && !pin_seen_reg;
   assign chip_cause = (pin_event && (in_run || in_halt)) || (watchdog_timeout && in_run); // R1
   // A pin edge in the same cycle wins over a time-out while halted
   assign warm_cause = watchdog_timeout && in_halt && !pin_event; // R2
   assign wake = (chip_cause && in_halt) || warm_cause;

   // Count runs from the load down to zero, then one more edge enters run
   assign poweron_load = 11'(reset_seq_pkg::POWERON_EXTRA_CLKS
      + reset_seq_pkg::STARTUP_DELAY_CLKS - 1); // R7
   assign wake_load = 11'(reset_seq_pkg::STARTUP_DELAY_CLKS - 1); // R6

   // Timer load: double length only at power-on
   assign start_timer = in_poweron || wake; // R6
   assign load_value = in_poweron ? poweron_load : wake_load; // R7

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   // A reset in the same cycle cancels a halt request
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         reset_seq_pkg::ST_POWERON: state_next = reset_seq_pkg::ST_STARTUP;
         reset_seq_pkg::ST_STARTUP:
            if (!timer_busy)
               state_next = reset_seq_pkg::ST_RUN;
         reset_seq_pkg::ST_RUN:
            if (halt_instruction && !chip_cause)
               state_next = reset_seq_pkg::ST_HALT;
         reset_seq_pkg::ST_HALT:
            if (wake)
               state_next = reset_seq_pkg::ST_STARTUP;
         default: state_next = reset_seq_pkg::ST_POWERON;
      endcase
   end

   // ------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------
   // Reset causes take priority over instruction updates in the same cycle
   always_comb
   begin
      to_next = to_reg;
      pdf_next = pdf_reg;
      if (warm_cause)
      begin
         to_next = 1'b1; // R5
         pdf_next = 1'b1; // R5
      end
      else if (pin_event && in_halt)
      begin
         to_next = 1'b0; // R4
         pdf_next = 1'b1; // R4
      end
      else if (watchdog_timeout && in_run)
         to_next = 1'b1; // R5
      else if (pin_event && in_run)
         to_next = to_reg; // R4
      // Instructions act only in run; halt wins over a clear
      else if (in_run && halt_instruction)
      begin
         to_next = 1'b0;
         pdf_next = 1'b1; // R11
      end
      else if (in_run && watchdog_clear_instruction)
      begin
         to_next = 1'b0;
         pdf_next = 1'b0; // R11
      end
   end

   // Flag, state and strobe registers; power-up clears both flags
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         state_reg <= reset_seq_pkg::ST_POWERON;
         to_reg <= 1'b0; // R4
         pdf_reg <= 1'b0; // R11
         chip_reset_reg <= 1'b1;
         warm_reset_reg <= 1'b0;
         pin_seen_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         to_reg <= to_next; // R3
         pdf_reg <= pdf_next; // R3
         chip_reset_reg <= chip_cause; // R1
         warm_reset_reg <= warm_cause; // R2
         pin_seen_reg <= !external_reset_pin_n;
      end
   end

   // ------------------------------------------------------------
   // Start-up delay timer
   // ------------------------------------------------------------
   startup_delay_timer delay_timer
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .start(start_timer),
      .load_value(load_value),
      .busy(timer_busy)
   );

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Hold covers power-on, delay and halt; pin held low also holds the core
   assign core_hold = !in_run || !external_reset_pin_n; // R6
   assign chip_reset = chip_reset_reg; // R8
   assign warm_reset = warm_reset_reg; // R2
   assign watchdog_counter_clear = chip_reset_reg || !external_reset_pin_n; // R9
   // Status flags and state straight from their registers
   assign halted = in_halt;
   assign watchdog_timeout_flag = to_reg;
   assign power_down_flag = pdf_reg;
   // Control registers load only on chip reset, display driver control on warm reset too; data registers never do
   assign ctrl_regs_load = chip_reset_reg; // R10 R12
   assign display_driver_control_load = chip_reset_reg || warm_reset_reg; // R13
   // Fixed initial values for the core and peripherals
   assign pc_reset_value = reset_seq_pkg::PC_RESET; // R8
   assign sp_reset_value = reset_seq_pkg::SP_RESET; // R8
   assign timer0_ctrl_init = reset_seq_pkg::TIMER0_CTRL_INIT; // R8
   assign timer1_ctrl_init = reset_seq_pkg::TIMER1_CTRL_INIT;
   assign intc0_init = reset_seq_pkg::INTC0_INIT; // R8
   assign intc1_init = reset_seq_pkg::INTC1_INIT;
   assign port_dir_init = reset_seq_pkg::PORT_DIR_INIT; // R8
   assign rtc_ctrl_init = reset_seq_pkg::RTC_CTRL_INIT;
   assign display_driver_control_init = reset_seq_pkg::DISPLAY_CTRL_INIT;
endmodule : mcu_reset_sequencer

// file: verif/reset_seq_props.sv
`timescale 1ns/1ps
// ------------------------------
// Sequencer port checks
// ------------------------------
module reset_seq_props
(
   // Every port of the sequencer
   input wire logic sys_clk, resetn, external_reset_pin_n, watchdog_timeout,
   input wire logic halt_instruction, watchdog_clear_instruction,
   input wire logic watchdog_timeout_flag, power_down_flag, core_hold, chip_reset,
   input wire logic warm_reset, watchdog_counter_clear, halted,
   input wire logic display_driver_control_load, ctrl_regs_load,
   input wire logic [11:0] pc_reset_value,
   input wire logic [2:0] sp_reset_value,
   input wire logic [7:0] timer0_ctrl_init, timer1_ctrl_init, intc0_init, intc1_init,
   input wire logic [7:0] port_dir_init, rtc_ctrl_init, display_driver_control_init
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Cycles since a warm reset; a counter replaces a long repetition
   logic [11:0] wake_cnt_reg;
   logic wake_on_reg;
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         wake_cnt_reg <= 12'h000;
         wake_on_reg <= 1'h0;
      end
      else if (warm_reset)
      begin
         wake_cnt_reg <= 12'h000;
         wake_on_reg <= 1'h1;
      end
      else if (wake_on_reg)
      begin
         wake_cnt_reg <= wake_cnt_reg + 12'h001;
         wake_on_reg <= core_hold;
      end
   end
   // Event to answer, one cycle later
   a_warm_in_halt:
   assert property (halted && watchdog_timeout |=> warm_reset && !chip_reset
      && watchdog_timeout_flag && power_down_flag) else $error("bad warm reset");
   a_wd_run_chip:
   assert property (!core_hold && !halted && watchdog_timeout |=> chip_reset
      && watchdog_timeout_flag && $stable(power_down_flag)) else $error("bad wd reset");
   a_pin_halt_wake:
   assert property (halted && $fell(external_reset_pin_n) && !watchdog_timeout
      |=> chip_reset && !watchdog_timeout_flag && power_down_flag) else $error("bad wake");
   a_pin_run_keep:
   assert property ($fell(external_reset_pin_n) && !halted && !$past(core_hold)
      |=> chip_reset && $stable(watchdog_timeout_flag) && $stable(power_down_flag))
      else $error("bad pin reset");
   a_halt_entry:
   assert property (!core_hold && halt_instruction && !watchdog_timeout |=> halted
      && power_down_flag && !watchdog_timeout_flag) else $error("bad halt entry");
   // Load strobes follow the reset pulses exactly; counter clear is only required on chip reset
   a_load_strobes:
   assert property (ctrl_regs_load == chip_reset && (chip_reset -> watchdog_counter_clear)
      && display_driver_control_load == (chip_reset | warm_reset)) else $error("bad load");
   a_wake_delay:
   assert property (wake_on_reg |-> wake_cnt_reg <= 12'h40D
      && (core_hold || wake_cnt_reg >= 12'h3F9)) else $error("bad wake delay");
   a_init_values:
   assert property (chip_reset |-> pc_reset_value == 12'h000 && sp_reset_value == 3'h0
      && port_dir_init == 8'hFF && timer0_ctrl_init == 8'h08 && intc0_init == 8'h00
      && display_driver_control_init == 8'h07 && timer1_ctrl_init == 8'h08
      && intc1_init == 8'h00 && rtc_ctrl_init == 8'h07) else $error("bad init values");
   // Main scenarios reached
   c_warm: cover property (warm_reset);
   c_wake_pin: cover property (halted && $fell(external_reset_pin_n));
   c_wd_chip: cover property (chip_reset && watchdog_timeout_flag);
endmodule : reset_seq_props

// file: verif/reset_partner.sv
`timescale 1ns/1ps
// ------------------------------
// Reset circuit and watchdog
// ------------------------------
module reset_partner
(
   // Clock and commands
   input wire logic sys_clk,
   input wire logic press,
   input wire logic fire,
   // Lines into the sequencer
   output logic external_reset_pin_n,
   output logic watchdog_timeout
);
   initial external_reset_pin_n = 1'h1;
   initial watchdog_timeout = 1'h0;
   // Registered so lines only move just after an edge
   always @(posedge sys_clk)
   begin
      external_reset_pin_n <= !press;
      watchdog_timeout <= fire;
   end
endmodule : reset_partner

// file: verif/tb_mcu_reset_sequencer.sv
`timescale 1ns/1ps
module tb_mcu_reset_sequencer;
   logic sys_clk = 1'h0, resetn = 1'h0, press = 1'h0, fire = 1'h0;
   logic halt_instruction = 1'h0, watchdog_clear_instruction = 1'h0;
   logic external_reset_pin_n, watchdog_timeout, watchdog_timeout_flag, power_down_flag;
   logic core_hold, chip_reset, warm_reset, watchdog_counter_clear, halted;
   logic display_driver_control_load, ctrl_regs_load;
   logic [11:0] pc_reset_value;
   logic [2:0] sp_reset_value;
   logic [7:0] timer0_ctrl_init, timer1_ctrl_init, intc0_init, intc1_init;
   logic [7:0] port_dir_init, rtc_ctrl_init, display_driver_control_init;
   int n_mismatch = 0, checks = 0, cycles = 0, n;
   always #5 sys_clk = ~sys_clk;
   mcu_reset_sequencer dut_u (.*);
   reset_partner far_u (.*);
   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Pulse fire and instructions for one cycle, hold press at its level, then wait out the partner's register stage
   task automatic act(input logic f, input logic p, input logic h, input logic c);
      @(posedge sys_clk);
      fire <= f;
      press <= p;
      halt_instruction <= h;
      watchdog_clear_instruction <= c;
      @(posedge sys_clk);
      fire <= 1'h0;
      halt_instruction <= 1'h0;
      watchdog_clear_instruction <= 1'h0;
      @(posedge sys_clk);
      #1;
   endtask : act
   task automatic wait_run(input int lo, input int hi);
      n = 0;
      while (core_hold === 1'h1 && n < 5000)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk(4'(n >= lo && n <= hi), 4'h1);
   endtask : wait_run
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_power_on;
      repeat (8) @(posedge sys_clk);
      resetn <= 1'h1;
      @(posedge sys_clk);
      #1;
      wait_run(2046, 2052);
      chk({chip_reset, warm_reset, watchdog_timeout_flag, power_down_flag}, 4'h0);
   endtask : t_power_on
   task automatic t_run_watchdog;
      act(1'h1, 1'h0, 1'h0, 1'h0);
      chk({chip_reset, warm_reset, watchdog_timeout_flag, power_down_flag}, 4'hA);
      chk({ctrl_regs_load, display_driver_control_load, watchdog_counter_clear, halted}, 4'hE);
      wait_run(0, 3);
   endtask : t_run_watchdog
   task automatic t_halt_watchdog;
      act(1'h0, 1'h0, 1'h1, 1'h0);
      chk({halted, warm_reset, watchdog_timeout_flag, power_down_flag}, 4'h9);
      act(1'h1, 1'h0, 1'h0, 1'h0);
      chk({chip_reset, warm_reset, watchdog_timeout_flag, power_down_flag}, 4'h7);
      chk({ctrl_regs_load, display_driver_control_load, 2'h0}, 4'h4);
      wait_run(1022, 1030);
      act(1'h0, 1'h0, 1'h0, 1'h1);
      chk({3'h0, power_down_flag}, 4'h0);
   endtask : t_halt_watchdog
   task automatic t_halt_pin;
      act(1'h0, 1'h0, 1'h1, 1'h0);
      act(1'h0, 1'h1, 1'h0, 1'h0);
      chk({chip_reset, warm_reset, watchdog_timeout_flag, power_down_flag}, 4'h9);
      chk({ctrl_regs_load, 1'h0, watchdog_counter_clear, halted}, 4'hA);
      act(1'h0, 1'h0, 1'h0, 1'h0);
      wait_run(0, 1100);
   endtask : t_halt_pin
   task automatic t_run_pin;
      act(1'h0, 1'h1, 1'h0, 1'h0);
      chk({chip_reset, core_hold, watchdog_timeout_flag, power_down_flag}, 4'hD);
      act(1'h0, 1'h0, 1'h0, 1'h0);
      wait_run(0, 5);
   endtask : t_run_pin
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   // Hang guard, well above the few thousand cycles needed
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         end_sim();
      end
   end
   initial
   begin
      t_power_on();
      t_run_watchdog();
      t_halt_watchdog();
      t_halt_pin();
      t_run_pin();
      end_sim();
   end
endmodule : tb_mcu_reset_sequencer
bind mcu_reset_sequencer reset_seq_props chk_u (.*);
